// ---- src/wfsr_regs.sv ----
// Wake, ground-shift, over-temperature and wire fault status register bank.
`timescale 1ns/1ps
module wfsr_regs
    import wfsr_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic       rst_pin_n_i,
    input  wire wfsr_acc_s  acc_i,
    output logic [7:0]      acc_rdata_o,
    output logic            acc_rvalid_o,
    output logic            parity_err_o,
    input  wire logic       parity_err_clr_i,
    input  wire logic [3:0] gnd_shift_above_i,
    input  wire logic       tx_stuck_flag_i,
    input  wire logic       network_wake_i,
    input  wire logic       chipsel_wake_i,
    input  wire logic [2:0] wake_input_i,
    input  wire logic       reg1_overtemp_i,
    input  wire logic       reg2_overtemp_i,
    input  wire logic       reg1_heat_warn_i,
    input  wire logic       reg2_heat_warn_i,
    input  wire logic [3:0] high_wire_event_i,
    input  wire logic [3:0] low_wire_event_i,
    output logic            reg1_enable_o,
    output logic            reg2_enable_o,
    output logic            batt_switch_force_off_o
);

    // =========================================================================
    // Access decode
    logic       par_ok;
    logic       wr_ok;
    logic       rd_gsl;
    logic       rd_wic;
    logic       rd_wis;
    logic       rd_ots;
    logic       rd_hwf;
    logic       rd_lwf;
    logic       wr_gsl;
    logic       wr_wic;
    logic       wr_ots;

    assign par_ok = (wfsr_parity(acc_i.data) == acc_i.parity);
    assign wr_ok  = acc_i.wr && par_ok;
    assign rd_gsl = acc_i.rd && (acc_i.addr == WFSR_GROUND_SHIFT_LEVEL);
    assign rd_wic = acc_i.rd && (acc_i.addr == WFSR_WAKE_INPUT_CONFIG);
    assign rd_wis = acc_i.rd && (acc_i.addr == WFSR_WAKE_INPUT_SOURCE);
    assign rd_ots = acc_i.rd && (acc_i.addr == WFSR_OVERTEMP_STATUS);
    assign rd_hwf = acc_i.rd && (acc_i.addr == WFSR_HIGH_WIRE_FAULT);
    assign rd_lwf = acc_i.rd && (acc_i.addr == WFSR_LOW_WIRE_FAULT);
    assign wr_gsl = wr_ok && (acc_i.addr == WFSR_GROUND_SHIFT_LEVEL);
    assign wr_wic = wr_ok && (acc_i.addr == WFSR_WAKE_INPUT_CONFIG);
    assign wr_ots = wr_ok && (acc_i.addr == WFSR_OVERTEMP_STATUS);

    // =========================================================================
    // Parity error flag
    logic       parity_err_q;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            parity_err_q <= 1'b0;
        end else begin
            parity_err_q <= (parity_err_q && !parity_err_clr_i)
                            || (acc_i.wr && !par_ok);
        end
    end
    assign parity_err_o = parity_err_q;

    // =========================================================================
    // Ground shift
    logic [1:0] thresh_q;
    logic       shift_q;
    logic       shift_hit;

    assign shift_hit = gnd_shift_above_i[thresh_q];

    // The reset pin is synchronous here, so a glitch that covers no rising clock edge is ignored.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            thresh_q <= WFSR_THRESH_RESET;
        end else if (!rst_pin_n_i) begin
            thresh_q <= WFSR_THRESH_RESET;
        end else if (wr_gsl) begin
            thresh_q <= acc_i.data[1:0];
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            shift_q <= 1'b0;
        end else begin
            shift_q <= (shift_q && !rd_gsl) || shift_hit;
        end
    end

    // =========================================================================
    // Wake configuration and events
    logic [1:0] wake_cfg_q;
    logic       net_wake_q;
    logic       cs_wake_q;
    logic [2:0] wake_prev_q;
    logic [2:0] wake_src_q;
    logic [2:0] wake_edge;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wake_cfg_q <= WFSR_WAKE_CFG_RESET;
        end else if (!rst_pin_n_i) begin
            wake_cfg_q <= WFSR_WAKE_CFG_RESET;
        end else if (wr_wic) begin
            wake_cfg_q <= acc_i.data[1:0];
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            net_wake_q <= 1'b0;
            cs_wake_q  <= 1'b0;
        end else begin
            net_wake_q <= (net_wake_q && !rd_wic) || network_wake_i;
            cs_wake_q  <= (cs_wake_q && !rd_wic) || chipsel_wake_i;
        end
    end

    always_comb begin
        wake_edge = 3'h0;
        unique case (wake_cfg_q)
            WFSR_WAKE_OFF:  wake_edge = 3'h0;
            WFSR_WAKE_RISE: wake_edge = wake_input_i & ~wake_prev_q;
            WFSR_WAKE_FALL: wake_edge = ~wake_input_i & wake_prev_q;
            WFSR_WAKE_BOTH: wake_edge = wake_input_i ^ wake_prev_q;
        endcase
    end

    function automatic logic [2:0] wake_latch3(input logic [2:0] q,
                                               input logic       clr,
                                               input logic [2:0] set);
        logic [3:0] r;
        r = wfsr_latch({1'b0, q}, clr, {1'b0, set});
        return r[2:0];
    endfunction

    // Edge history runs from power-on so enabling a mode never sees a stale level.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wake_prev_q <= 3'h0;
            wake_src_q  <= 3'h0;
        end else begin
            wake_prev_q <= wake_input_i;
            wake_src_q  <= wake_latch3(wake_src_q, rd_wis, wake_edge);
        end
    end

    // =========================================================================
    // Over-temperature and regulator control
    logic       r1_off_q;
    logic       r2_off_q;
    logic       r2_hold_q;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            r1_off_q <= 1'b0;
            r2_off_q <= 1'b0;
        end else begin
            r1_off_q <= (r1_off_q && !rd_ots) || reg1_overtemp_i;
            r2_off_q <= (r2_off_q && !rd_ots) || reg2_overtemp_i;
        end
    end

    // Clearing the flag by a read does not restart V2; only the control write does.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            r2_hold_q <= 1'b0;
        end else begin
            if (reg2_overtemp_i) begin
                r2_hold_q <= 1'b1;
            end else if (wr_ots && !acc_i.data[WFSR_OTS_R2OFF_BIT]) begin
                r2_hold_q <= 1'b0;
            end
        end
    end

    // V1 comes back once its flag has been read clear and the heat has gone.
    assign reg1_enable_o           = !r1_off_q && !reg1_overtemp_i;
    assign reg2_enable_o           = !r2_hold_q && !reg2_overtemp_i;
    assign batt_switch_force_off_o = r2_hold_q || reg2_overtemp_i;

    // =========================================================================
    // Wire faults
    logic [3:0] hwf_q;
    logic [3:0] lwf_q;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            hwf_q <= 4'h0;
            lwf_q <= 4'h0;
        end else begin
            hwf_q <= wfsr_latch(hwf_q, rd_hwf, high_wire_event_i);
            lwf_q <= wfsr_latch(lwf_q, rd_lwf, low_wire_event_i);
        end
    end

    // =========================================================================
    // Read data, taken before any clear lands
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic       rvalid_q;

    always_comb begin
        rdata_d = WFSR_READ_ZERO;
        unique case (acc_i.addr)
            WFSR_GROUND_SHIFT_LEVEL: rdata_d = {4'h0, tx_stuck_flag_i, shift_q, thresh_q};
            WFSR_WAKE_INPUT_CONFIG:  rdata_d = {4'h0, cs_wake_q, net_wake_q, wake_cfg_q};
            WFSR_WAKE_INPUT_SOURCE:  rdata_d = {5'h00, wake_src_q};
            WFSR_WAKE_INPUT_LEVEL:   rdata_d = {5'h00, wake_input_i};
            WFSR_OVERTEMP_STATUS:    rdata_d = {4'h0, reg2_heat_warn_i, reg1_heat_warn_i,
                                                r2_off_q, r1_off_q};
            WFSR_HIGH_WIRE_FAULT:    rdata_d = {4'h0, hwf_q};
            WFSR_LOW_WIRE_FAULT:     rdata_d = {4'h0, lwf_q};
            default:                 rdata_d = WFSR_READ_ZERO;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_q  <= WFSR_READ_ZERO;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= acc_i.rd;
            if (acc_i.rd) begin
                rdata_q <= rdata_d;
            end
        end
    end
    assign acc_rdata_o  = rdata_q;
    assign acc_rvalid_o = rvalid_q;

    // =========================================================================
    // Checks
    sequence bad_write_s;
        acc_i.wr && (wfsr_parity(acc_i.data) != acc_i.parity);
    endsequence

    sequence thr_write_s;
        acc_i.wr && par_ok && (acc_i.addr == WFSR_GROUND_SHIFT_LEVEL) && rst_pin_n_i;
    endsequence

    thresh_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        thr_write_s |=> (thresh_q == $past(acc_i.data[1:0])))
        else $error("threshold write not stored");

    parity_block_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        bad_write_s |=> ($stable(thresh_q) || !$past(rst_pin_n_i)) && parity_err_o)
        else $error("bad parity write accepted");

    pin_clears_cfg_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !rst_pin_n_i |=> (wake_cfg_q == WFSR_WAKE_CFG_RESET) && (thresh_q == 2'h0))
        else $error("reset pin did not clear config");

    shift_hold_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        shift_q && !rd_gsl |=> shift_q)
        else $error("ground shift flag lost without read");

    set_wins_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        rd_hwf && (high_wire_event_i != 4'h0) |=>
            ((hwf_q & $past(high_wire_event_i)) == $past(high_wire_event_i)))
        else $error("fault event lost during clearing read");

    read_old_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        rd_lwf |=> acc_rvalid_o && (acc_rdata_o == {4'h0, $past(lwf_q)}))
        else $error("read did not return pre-clear value");

    rise_wake_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (wake_cfg_q == WFSR_WAKE_RISE) && wake_input_i[0] && !wake_prev_q[0]
            |=> wake_src_q[0])
        else $error("rising wake edge not latched");

    v2_stays_off_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !reg2_enable_o && !reg2_overtemp_i && !wr_ots |=> !reg2_enable_o)
        else $error("V2 restarted without control write");

    v3_follows_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        reg2_overtemp_i |-> batt_switch_force_off_o && !reg2_enable_o ##1
            batt_switch_force_off_o)
        else $error("V3 not forced off by V2 overheat");

    ot_latch_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        reg1_overtemp_i |=> r1_off_q)
        else $error("V1 overheat flag not latched");

    tx_stuck_live_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        rd_gsl |=> (acc_rdata_o[WFSR_GSL_TXSTUCK_BIT] == $past(tx_stuck_flag_i)))
        else $error("stuck transmit status not shown live");

    shift_set_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        shift_hit |=> shift_q)
        else $error("ground shift flag not set");

    cfg_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        wr_wic && rst_pin_n_i |=> (wake_cfg_q == $past(acc_i.data[1:0])))
        else $error("wake edge config write not stored");

    wake_off_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (wake_cfg_q == WFSR_WAKE_OFF) && !rd_wis |=> (wake_src_q == $past(wake_src_q)))
        else $error("wake source set while wake is disabled");

    fall_wake_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (wake_cfg_q == WFSR_WAKE_FALL) && !wake_input_i[1] && wake_prev_q[1]
            |=> wake_src_q[1])
        else $error("falling wake edge not latched");

    both_wake_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (wake_cfg_q == WFSR_WAKE_BOTH) && (wake_input_i[2] != wake_prev_q[2])
            |=> wake_src_q[2])
        else $error("wake edge in both mode not latched");

    net_wake_set_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        network_wake_i |=> net_wake_q)
        else $error("network wake event not latched");

    wake_clear_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        rd_wic && !network_wake_i && !chipsel_wake_i |=> !net_wake_q && !cs_wake_q)
        else $error("wake flags not cleared by read");

    level_live_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        acc_i.rd && (acc_i.addr == WFSR_WAKE_INPUT_LEVEL)
            |=> (acc_rdata_o == {5'h00, $past(wake_input_i)}))
        else $error("wake input level not shown live");

    warn_live_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        rd_ots |=> (acc_rdata_o[WFSR_OTS_R2WARN_BIT] == $past(reg2_heat_warn_i))
            && (acc_rdata_o[WFSR_OTS_R1WARN_BIT] == $past(reg1_heat_warn_i)))
        else $error("heat pre-warning not shown live");

    v2_latch_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        reg2_overtemp_i |=> r2_off_q && !reg2_enable_o)
        else $error("V2 overheat did not switch V2 off");

    v2_restart_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        wr_ots && !acc_i.data[WFSR_OTS_R2OFF_BIT] && !reg2_overtemp_i
            |=> (reg2_enable_o == !reg2_overtemp_i))
        else $error("V2 not restarted by control write");

    low_fault_set_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (low_wire_event_i != 4'h0) |=>
            ((lwf_q & $past(low_wire_event_i)) == $past(low_wire_event_i)))
        else $error("low wire fault event not latched");

    parity_sticky_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        parity_err_o && !parity_err_clr_i |=> parity_err_o)
        else $error("parity error flag lost without clear");

endmodule

// ---- src/wfsr_pkg.sv ----
// Constants, types and helpers shared by the wake and fault status register bank.
// =============================================================================
// Summary of operation
// - Two-bit ground-shift threshold selector, writable
// - Ground-shift flag latched until register read
// - Power-on clears all; reset pin clears selector
// - Transmit stuck-dominant status shown live
// - Wake edge field: off, rise, fall, both
// - Network and chip-select wake flags, read-cleared
// - Reset pin clears wake edge field
// - Wake input events latched per input, read-cleared
// - Live wake input levels shown unlatched
// - Regulator overheat: switch off, latch flag
// - V2 restarts only on written zero
// - Pre-warning flags follow condition directly
// - V2 overheat also forces V3 off
// - Overheat bits zero after power-on
// - High wire fault bits latched, read-cleared
// - Low wire fault bits latched, read-cleared
// - Writes need four good parity bits
package wfsr_pkg;

    // =========================================================================
    // Register offsets
    localparam logic [7:0] WFSR_GROUND_SHIFT_LEVEL = 8'h0A;
    localparam logic [7:0] WFSR_WAKE_INPUT_CONFIG  = 8'h0C;
    localparam logic [7:0] WFSR_WAKE_INPUT_SOURCE  = 8'h0F;
    localparam logic [7:0] WFSR_WAKE_INPUT_LEVEL   = 8'h11;
    localparam logic [7:0] WFSR_OVERTEMP_STATUS    = 8'h12;
    localparam logic [7:0] WFSR_HIGH_WIRE_FAULT    = 8'h14;
    localparam logic [7:0] WFSR_LOW_WIRE_FAULT     = 8'h17;

    // =========================================================================
    // Field positions
    localparam int WFSR_GSL_SHIFT_BIT   = 2;
    localparam int WFSR_GSL_TXSTUCK_BIT = 3;
    localparam int WFSR_WIC_NET_BIT     = 2;
    localparam int WFSR_WIC_CS_BIT      = 3;
    localparam int WFSR_OTS_R1OFF_BIT   = 0;
    localparam int WFSR_OTS_R2OFF_BIT   = 1;
    localparam int WFSR_OTS_R1WARN_BIT  = 2;
    localparam int WFSR_OTS_R2WARN_BIT  = 3;

    // =========================================================================
    // Reset values and encodings
    localparam logic [1:0] WFSR_THRESH_RESET = 2'h0;
    localparam logic [1:0] WFSR_WAKE_CFG_RESET = 2'h0;
    localparam logic [1:0] WFSR_WAKE_OFF  = 2'h0;
    localparam logic [1:0] WFSR_WAKE_RISE = 2'h1;
    localparam logic [1:0] WFSR_WAKE_FALL = 2'h2;
    localparam logic [1:0] WFSR_WAKE_BOTH = 2'h3;
    localparam logic [7:0] WFSR_READ_ZERO = 8'h00;

    // =========================================================================
    // Deserialised access from the serial port.
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [3:0] data;
        logic [3:0] parity;
    } wfsr_acc_s;

    // Parity expected for a data nibble.
    function automatic logic [3:0] wfsr_parity(input logic [3:0] d);
        return {d[3] ^ d[0], d[3] ^ d[2], d[2] ^ d[1], d[1] ^ d[0]};
    endfunction

    // Latch with read clear; a set in the clearing cycle survives.
    function automatic logic [3:0] wfsr_latch(input logic [3:0] q,
                                              input logic       clr,
                                              input logic [3:0] set);
        return (clr ? 4'h0 : q) | set;
    endfunction

endpackage

// ---- test/wfsr_host.sv ----
// Host model that issues decoded register accesses toward the status bank.
`timescale 1ns/1ps
module wfsr_host
    import wfsr_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output wfsr_acc_s       acc_o
);
    // =========================================================================
    // Bus tasks
    task automatic reset_bus();
        acc_o = '0;
    endtask

    // Idle fields show the inverse of the last value, so stale data never looks valid.
    task automatic idle_bus();
        acc_o.rd     = 1'b0;
        acc_o.wr     = 1'b0;
        acc_o.addr   = ~acc_o.addr;
        acc_o.data   = ~acc_o.data;
        acc_o.parity = ~acc_o.parity;
    endtask

    task automatic host_write(input logic [7:0] a, input logic [3:0] d, input logic bad);
        acc_o.addr   = a;
        acc_o.data   = d;
        acc_o.parity = {d[3] ^ d[0], d[3] ^ d[2], d[2] ^ d[1], d[1] ^ d[0]} ^ {3'h0, bad};
        acc_o.wr     = 1'b1;
        @(posedge core_clk_i);
        #1;
        idle_bus();
        // One idle cycle ends every access, so back-to-back calls never re-drive a strobe.
        @(posedge core_clk_i);
        #1;
    endtask

    // The wait for the answer is bounded; a count above three means no answer came.
    task automatic host_read(input logic [7:0] a, output logic [7:0] d, output int lat);
        acc_o.addr = a;
        acc_o.rd   = 1'b1;
        @(posedge core_clk_i);
        #1;
        idle_bus();
        lat = 0;
        while (rvalid_i !== 1'b1 && lat < 4) begin
            @(posedge core_clk_i);
            #1;
            lat++;
        end
        d = rdata_i;
        @(posedge core_clk_i);
        #1;
    endtask
endmodule

// ---- test/wake_fault_status_regs_test.sv ----
// Self-checking testbench for the wake and fault status register bank.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module wake_fault_status_regs_test;
    import wfsr_pkg::*;
    // =========================================================================
    // Signals
    logic       core_clk, reset, rst_pin_n, par_clr, tx_stuck, net_wake, cs_wake;
    logic       ot1, ot2, warn1, warn2, rvalid, par_err, en1, en2, v3_off;
    logic [3:0] gnd_above, hi_ev, lo_ev, h, l;
    logic [2:0] wake_in, k;
    logic [7:0] rdata, rd;
    wfsr_acc_s  acc;
    int         failures, compares, seed, lat;
    localparam logic [7:0] ADDRS [8] = '{8'h0A, 8'h0C, 8'h0F, 8'h11, 8'h12, 8'h14, 8'h17, 8'h13};

    wfsr_regs i_wfsr_regs (.core_clk_i(core_clk), .reset_i(reset), .rst_pin_n_i(rst_pin_n),
        .acc_i(acc), .acc_rdata_o(rdata), .acc_rvalid_o(rvalid), .parity_err_o(par_err),
        .parity_err_clr_i(par_clr), .gnd_shift_above_i(gnd_above), .tx_stuck_flag_i(tx_stuck),
        .network_wake_i(net_wake), .chipsel_wake_i(cs_wake), .wake_input_i(wake_in),
        .reg1_overtemp_i(ot1), .reg2_overtemp_i(ot2), .reg1_heat_warn_i(warn1),
        .reg2_heat_warn_i(warn2), .high_wire_event_i(hi_ev), .low_wire_event_i(lo_ev),
        .reg1_enable_o(en1), .reg2_enable_o(en2), .batt_switch_force_off_o(v3_off));
    wfsr_host i_wfsr_host (.core_clk_i(core_clk), .rdata_i(rdata), .rvalid_i(rvalid),
        .acc_o(acc));

    // =========================================================================
    // Helpers
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic complete_run();
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        i_wfsr_host.host_read(a, rd, lat);
        if (lat > 3) begin
            failures++;
            complete_run();
        end else begin
            `CHK(lat, 0)
            `CHK(rd, e)
        end
    endtask

    // Expected wake sources after the inputs set in lvl moved once in the given direction.
    function automatic logic [7:0] wake_exp(input int         m,
                                            input logic       fall,
                                            input logic [2:0] lvl);
        logic hit;
        hit = fall ? m[1] : m[0];
        return hit ? {5'h00, lvl} : 8'h00;
    endfunction

    // =========================================================================
    // Scenarios
    initial begin
        i_wfsr_host.reset_bus();
        {reset, rst_pin_n, par_clr, tx_stuck, net_wake, cs_wake} = 6'b110000;
        {ot1, ot2, warn1, warn2, gnd_above, hi_ev, lo_ev, wake_in} = '0;
        seed = 73;
        repeat (10) @(posedge core_clk);
        #1;
        reset = 1'b0;
        foreach (ADDRS[i]) chk_rd(ADDRS[i], 8'h00);
        `CHK({en1, en2, v3_off}, 3'b110)
        for (int c = 0; c < 4; c++) begin
            i_wfsr_host.host_write(8'h0A, 4'(c), 1'b0);
            tx_stuck = c[0];
            gnd_above = ~(4'h1 << c);
            tick(1);
            chk_rd(8'h0A, {4'h0, c[0], 1'b0, 2'(c)});
            gnd_above = 4'h1 << c;
            tick(1);
            gnd_above = 4'h0;
            chk_rd(8'h0A, {4'h0, c[0], 1'b1, 2'(c)});
            chk_rd(8'h0A, {4'h0, c[0], 1'b0, 2'(c)});
        end
        i_wfsr_host.host_write(8'h0A, 4'h1, 1'b1);
        `CHK(par_err, 1'b1)
        chk_rd(8'h0A, 8'h0B);
        par_clr = 1'b1;
        tick(1);
        par_clr = 1'b0;
        tick(1);
        `CHK(par_err, 1'b0)
        for (int m = 0; m < 4; m++) begin
            i_wfsr_host.host_write(8'h0C, 4'(m), 1'b0);
            k = 3'($random(seed));
            wake_in = k;
            tick(1);
            chk_rd(8'h0F, wake_exp(m, 1'b0, k));
            chk_rd(8'h11, {5'h0, k});
            wake_in = 3'h0;
            tick(1);
            chk_rd(8'h0F, wake_exp(m, 1'b1, k));
        end
        i_wfsr_host.host_write(8'h11, 4'hF, 1'b0);
        chk_rd(8'h11, 8'h00);
        net_wake = 1'b1;
        tick(1);
        net_wake = 1'b0;
        cs_wake = 1'b1;
        fork
            chk_rd(8'h0C, 8'h07);
            begin
                tick(1);
                cs_wake = 1'b0;
            end
        join
        chk_rd(8'h0C, 8'h0B);
        rst_pin_n = 1'b0;
        tick(2);
        i_wfsr_host.host_write(8'h0A, 4'h2, 1'b0);
        rst_pin_n = 1'b1;
        chk_rd(8'h0A, 8'h08);
        chk_rd(8'h0C, 8'h00);
        repeat (8) begin
            h = 4'($random(seed));
            l = 4'($random(seed));
            {hi_ev, lo_ev} = {h, l};
            tick(1);
            {hi_ev, lo_ev} = 8'h00;
            chk_rd(8'h14, {4'h0, h});
            chk_rd(8'h17, {4'h0, l});
        end
        chk_rd(8'h14, 8'h00);
        hi_ev = 4'h9;
        fork
            chk_rd(8'h14, 8'h00);
            begin
                tick(1);
                hi_ev = 4'h0;
            end
        join
        chk_rd(8'h14, 8'h09);
        {ot2, warn1, warn2} = 3'b111;
        tick(1);
        `CHK({en2, v3_off}, 2'b01)
        chk_rd(8'h12, 8'h0E);
        {ot2, warn1, warn2} = 3'b000;
        tick(2);
        chk_rd(8'h12, 8'h02);
        chk_rd(8'h12, 8'h00);
        `CHK(en2, 1'b0)
        i_wfsr_host.host_write(8'h12, 4'h0, 1'b0);
        `CHK({en2, v3_off}, 2'b10)
        ot1 = 1'b1;
        tick(1);
        `CHK(en1, 1'b0)
        ot1 = 1'b0;
        chk_rd(8'h12, 8'h01);
        chk_rd(8'h12, 8'h00);
        tick(1);
        `CHK(en1, 1'b1)
        complete_run();
    end
endmodule
